/* File: logic/dram_odt_controller.sv */
// Purpose: controller end driving ck, cke, odt and commands
// Assumes: software reaches the registers over apb, zero wait states
// Notes: one command per ck period; pins change at ck falling
`timescale 1ns/1ps
`default_nettype none
`include "odt_cfg.svh"
module dram_odt_controller (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  odt_link_if.ctrl link
);
  logic [1:0] div;
  logic odt_req;
  logic calibrated;
  logic rst_pin;
  logic pend;
  odt_pkg::op_t pend_op;
  logic [15:0] pend_arg;
  logic err;
  logic [15:0] mr0s;
  logic [15:0] mr1s;
  logic [15:0] mr2s;
  logic sr_active;
  logic [3:0] high_cnt;
  logic [4:0] quiet;
  logic [4:0] read_hold;

  logic fall;
  logic acc;
  logic wr_acc;
  logic hit;
  logic [2:0] code_new;
  logic [2:0] code_cur;
  logic needs_quiet;
  logic refuse;
  logic can_issue;
  logic want_odt;
  logic next_odt;
  logic [4:0] lat;

  assign fall = link.ck && (div == `CK_HALF_CYC);
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign hit = (paddr == `REG_CTRL) || (paddr == `REG_CMD) || (paddr == `REG_STATUS);
  assign code_new = {pend_arg[`MR1_RTT_B9], pend_arg[`MR1_RTT_B6], pend_arg[`MR1_RTT_B2]};
  assign code_cur = {mr1s[`MR1_RTT_B9], mr1s[`MR1_RTT_B6], mr1s[`MR1_RTT_B2]};
  assign lat = odt_pkg::sync_latency(mr0s, mr1s, mr2s);
  assign needs_quiet = (pend_op == odt_pkg::op_read) || (pend_op == odt_pkg::op_sr_enter);
  assign refuse = ((pend_op == odt_pkg::op_mrs1) && code_new >= 3'h6) ||
    ((pend_op == odt_pkg::op_write_bl8 || pend_op == odt_pkg::op_write_bc4) && link.odt &&
    !(mr2s[`MR2_WR_B9] | mr2s[`MR2_WR_B10]) && (code_cur == 3'h4 || code_cur == 3'h5));
  assign can_issue = pend && !refuse && (!needs_quiet || (!link.odt && quiet > lat));
  assign want_odt = odt_req && calibrated && !mr1s[`MR1_DLL_DIS_BIT] && !sr_active &&
    read_hold == 5'h0 && !(pend && needs_quiet);
  assign next_odt = want_odt || (link.odt && high_cnt > 4'h1);

  // apb slave, answer in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `REG_CTRL: prdata <= {29'h0, rst_pin, calibrated, odt_req};
          `REG_CMD: prdata <= {pend_arg, 12'h0, pend_op};
          `REG_STATUS: prdata <= {28'h0, sr_active, err, link.odt, pend};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      odt_req <= 1'b0;
      calibrated <= 1'b0;
      rst_pin <= 1'b0;
    end else if (wr_acc && paddr == `REG_CTRL) begin
      odt_req <= pwdata[0];
      calibrated <= pwdata[1];
      rst_pin <= pwdata[2];
    end
  end

  // command queue of one, refusal flag sticky with set over clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend <= 1'b0;
      pend_op <= odt_pkg::op_nop;
      pend_arg <= 16'h0;
      err <= 1'b0;
    end else begin
      if (wr_acc && paddr == `REG_STATUS && pwdata[2]) begin
        err <= 1'b0;
      end
      if (fall && pend && refuse) begin
        pend <= 1'b0;
        err <= 1'b1;
      end else if (fall && can_issue) begin
        pend <= 1'b0;
      end else if (wr_acc && paddr == `REG_CMD && !pend) begin
        pend <= 1'b1;
        pend_op <= odt_pkg::op_t'(pwdata[3:0]);
        pend_arg <= pwdata[31:16];
      end
    end
  end

  // link clock divider
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div <= 2'h0;
      link.ck <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == `CK_HALF_CYC) begin
        link.ck <= !link.ck;
      end
    end
  end

  // pins and shadow state, updated at ck falling
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link.cke <= 1'b1;
      link.odt <= 1'b0;
      link.reset_n <= 1'b0;
      link.op <= odt_pkg::op_nop;
      link.arg <= 16'h0;
      mr0s <= 16'h0;
      mr1s <= 16'h0;
      mr2s <= 16'h0;
      sr_active <= 1'b0;
      high_cnt <= 4'h0;
      quiet <= 5'h0;
      read_hold <= 5'h0;
    end else if (fall) begin
      link.reset_n <= rst_pin;
      link.odt <= next_odt;
      link.op <= can_issue ? pend_op : odt_pkg::op_nop;
      link.arg <= can_issue ? pend_arg : 16'h0;
      quiet <= next_odt ? 5'h0 : (quiet == 5'h1f ? quiet : quiet + 5'h1);
      read_hold <= (read_hold != 5'h0) ? read_hold - 5'h1 : 5'h0;
      if (next_odt && !link.odt) begin
        high_cnt <= `MIN_HIGH_SHORT + 4'h1;
      end else if (can_issue && next_odt && pend_op == odt_pkg::op_write_bl8) begin
        high_cnt <= `MIN_HIGH_LONG + 4'h1;
      end else if (can_issue && next_odt && pend_op == odt_pkg::op_write_bc4) begin
        high_cnt <= (high_cnt > `MIN_HIGH_SHORT + 4'h1) ? high_cnt : `MIN_HIGH_SHORT + 4'h1;
      end else if (high_cnt != 4'h0) begin
        high_cnt <= high_cnt - 4'h1;
      end
      if (can_issue) begin
        unique case (pend_op)
          odt_pkg::op_mrs0: mr0s <= pend_arg;
          odt_pkg::op_mrs1: mr1s <= pend_arg;
          odt_pkg::op_mrs2: mr2s <= pend_arg;
          odt_pkg::op_read: read_hold <= lat + `READ_HOLD_CK;
          odt_pkg::op_sr_enter: sr_active <= 1'b1;
          odt_pkg::op_sr_exit: sr_active <= 1'b0;
          odt_pkg::op_pd_enter: link.cke <= 1'b0;
          odt_pkg::op_pd_exit: link.cke <= 1'b1;
          default: ;
        endcase
      end
    end
  end
endmodule // dram_odt_controller
`default_nettype wire

/* File: logic/dram_odt_device.sv */
// Purpose: termination control logic of the memory device
// Assumes: link pins come from another domain and pass two flip-flops
// Notes: dq_width 4, 8 or 16 selects the terminated pin set
`timescale 1ns/1ps
`default_nettype none
`include "odt_cfg.svh"
module dram_odt_device #(
  parameter int DQ_WIDTH = 8,
  parameter int MAX_LAT = 24,
  localparam int LANES = (DQ_WIDTH == 16) ? 2 : 1,
  localparam int BASE_PINS = DQ_WIDTH + 3 * LANES,
  localparam int NUM_PINS = BASE_PINS + ((DQ_WIDTH == 8) ? 2 : 0)
) (
  input wire logic ref_clk,
  input wire logic srst,
  odt_link_if.dram link,
  output logic [NUM_PINS-1:0] term_pins,
  output odt_pkg::term_sel_t term_sel,
  output logic [3:0] nominal_divisor,
  output logic [1:0] write_code,
  output logic async_mode,
  output logic illegal_code,
  output logic write_value_fault
);
  localparam int ASYNC_RAW = `ASYNC_DLY_MAX_PS / `REF_CLK_PS;
  localparam int ASYNC_CYC = (ASYNC_RAW < 1) ? 1 : ASYNC_RAW;

  if (DQ_WIDTH != 4 && DQ_WIDTH != 8 && DQ_WIDTH != 16) begin : bad_width
    $error("dram_odt_device supports widths 4, 8 and 16 only");
  end
  if (MAX_LAT < 21) begin : bad_lat
    $error("dram_odt_device needs a line of at least 21 stages");
  end
  if (ASYNC_CYC > 15) begin : bad_async
    $error("asynchronous delay counter too narrow");
  end

  // pin synchroniser: ck, cke, odt, reset_n, op, arg
  logic [23:0] pins_s1;
  logic [23:0] pins_s2;
  logic ck_prev;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins_s1 <= 24'h0;
      pins_s2 <= 24'h0;
      ck_prev <= 1'b0;
    end else begin
      pins_s1 <= {link.ck, link.cke, link.odt, link.reset_n, link.op, link.arg};
      pins_s2 <= pins_s1;
      ck_prev <= pins_s2[23];
    end
  end

  logic ck_rise;
  logic cke_lvl;
  logic odt_lvl;
  logic hard_rst;
  odt_pkg::op_t op;
  logic [15:0] arg;
  assign ck_rise = pins_s2[23] & ~ck_prev;
  assign cke_lvl = pins_s2[22];
  assign odt_lvl = pins_s2[21];
  assign hard_rst = srst | ~pins_s2[20];
  assign op = odt_pkg::op_t'(pins_s2[19:16]);
  assign arg = pins_s2[15:0];

  // mode registers
  logic [15:0] mr0;
  logic [15:0] mr1;
  logic [15:0] mr2;

  always_ff @(posedge ref_clk) begin
    if (hard_rst) begin
      mr0 <= 16'h0;
      mr1 <= 16'h0;
      mr2 <= 16'h0;
    end else if (ck_rise) begin
      if (op == odt_pkg::op_mrs0) begin
        mr0 <= arg;
      end
      if (op == odt_pkg::op_mrs1) begin
        mr1 <= arg;
      end
      if (op == odt_pkg::op_mrs2) begin
        mr2 <= arg;
      end
    end
  end

  logic [2:0] rtt_code;
  logic dll_off;
  logic nom_en;
  logic wr_en;
  logic [4:0] lat;
  assign rtt_code = {mr1[`MR1_RTT_B9], mr1[`MR1_RTT_B6], mr1[`MR1_RTT_B2]};
  assign dll_off = mr1[`MR1_DLL_DIS_BIT];
  assign nom_en = (rtt_code != 3'h0) && (rtt_code < 3'h6);
  assign wr_en = mr2[`MR2_WR_B9] | mr2[`MR2_WR_B10];
  assign lat = odt_pkg::sync_latency(mr0, mr1, mr2);

  // operating mode: synchronous or asynchronous timing
  odt_pkg::dev_mode_t mode;
  logic cke_q;
  logic [3:0] relock_cnt;

  always_ff @(posedge ref_clk) begin
    if (hard_rst) begin
      mode <= odt_pkg::dm_normal;
      cke_q <= 1'b1;
      relock_cnt <= 4'h0;
    end else if (ck_rise) begin
      cke_q <= cke_lvl;
      unique case (mode)
        odt_pkg::dm_normal: begin
          if (op == odt_pkg::op_sr_enter) begin
            mode <= odt_pkg::dm_self_refresh;
          end else if (cke_q && !cke_lvl && !mr0[`MR0_PD_FAST_BIT]) begin
            mode <= odt_pkg::dm_pd_slow;
          end
        end
        odt_pkg::dm_self_refresh: begin
          if (op == odt_pkg::op_sr_exit) begin
            mode <= odt_pkg::dm_normal;
          end
        end
        odt_pkg::dm_pd_slow: begin
          if (cke_lvl) begin
            mode <= odt_pkg::dm_relock;
            relock_cnt <= `RELOCK_CK;
          end
        end
        odt_pkg::dm_relock: begin
          relock_cnt <= relock_cnt - 4'h1;
          if (relock_cnt == 4'h1) begin
            mode <= odt_pkg::dm_normal;
          end
        end
      endcase
    end
  end

  logic async_now;
  assign async_now = (mode == odt_pkg::dm_pd_slow) || (mode == odt_pkg::dm_relock);

  // synchronous path: odt and write registration delayed by the latency
  logic [2:0] line_in;
  logic [2:0] line_out;
  assign line_in = {odt_lvl, op == odt_pkg::op_write_bl8, op == odt_pkg::op_write_bc4};

  term_delay_line #(.WIDTH(3), .DEPTH(MAX_LAT)) u_line (
    .ref_clk(ref_clk),
    .clear(hard_rst),
    .step(ck_rise),
    .din(line_in),
    .tap(lat),
    .dout(line_out)
  );

  // write burst window, opened when the delayed write arrives
  logic [2:0] burst_cnt;

  always_ff @(posedge ref_clk) begin
    if (hard_rst) begin
      burst_cnt <= 3'h0;
    end else if (ck_rise) begin
      if (line_out[1]) begin
        burst_cnt <= `BURST_CK_BL8;
      end else if (line_out[0]) begin
        burst_cnt <= `BURST_CK_BC4;
      end else if (burst_cnt != 3'h0) begin
        burst_cnt <= burst_cnt - 3'h1;
      end
    end
  end

  // asynchronous path: follows the pin after a fixed delay
  logic async_level;
  logic [3:0] async_cnt;

  always_ff @(posedge ref_clk) begin
    if (hard_rst) begin
      async_level <= 1'b0;
      async_cnt <= 4'h0;
    end else if (odt_lvl == async_level) begin
      async_cnt <= 4'h0;
    end else if (async_cnt == 4'(ASYNC_CYC - 1)) begin
      async_level <= odt_lvl;
      async_cnt <= 4'h0;
    end else begin
      async_cnt <= async_cnt + 4'h1;
    end
  end

  // termination selection
  logic odt_eff;
  logic allowed;
  odt_pkg::term_sel_t next_term_sel;
  assign odt_eff = async_now ? async_level : line_out[2];
  assign allowed = !dll_off && (mode != odt_pkg::dm_self_refresh);

  always_comb begin
    next_term_sel = odt_pkg::ts_off;
    if (allowed && odt_eff) begin
      if (wr_en && burst_cnt != 3'h0 && !async_now) begin
        next_term_sel = odt_pkg::ts_write;
      end else if (nom_en) begin
        next_term_sel = odt_pkg::ts_nominal;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (hard_rst) begin
      term_sel <= odt_pkg::ts_off;
    end else begin
      // same cycle as the pin set, one clock after the delayed odt arrives
      term_sel <= next_term_sel;
    end
  end

  // pin set: data, strobes, masks, optional termination strobe
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    always_ff @(posedge ref_clk) begin
      if (hard_rst) begin
        term_pins[i] <= 1'b0;
      end else begin
        term_pins[i] <= (next_term_sel != odt_pkg::ts_off) &&
          (i < BASE_PINS || mr1[`MR1_TERMINATION_STROBE_BIT]);
      end
    end
  end

  // value decode and status flags
  always_ff @(posedge ref_clk) begin
    if (hard_rst) begin
      nominal_divisor <= 4'h0;
      write_code <= 2'h0;
      async_mode <= 1'b0;
      illegal_code <= 1'b0;
      write_value_fault <= 1'b0;
    end else begin
      unique case (rtt_code)
        3'h1: nominal_divisor <= 4'h4;
        3'h2: nominal_divisor <= 4'h2;
        3'h3: nominal_divisor <= 4'h6;
        3'h4: nominal_divisor <= 4'hc;
        3'h5: nominal_divisor <= 4'h8;
        default: nominal_divisor <= 4'h0;
      endcase
      write_code <= {mr2[`MR2_WR_B10], mr2[`MR2_WR_B9]};
      async_mode <= async_now;
      illegal_code <= (rtt_code >= 3'h6);
      if (next_term_sel == odt_pkg::ts_nominal && burst_cnt != 3'h0 &&
          (rtt_code == 3'h4 || rtt_code == 3'h5)) begin
        write_value_fault <= 1'b1;
      end
    end
  end
endmodule // dram_odt_device
`default_nettype wire

/* File: logic/odt_cfg.svh */
// Purpose: constants for the termination control link and both of its ends
// Assumes: sized literals; ref_clk period of 40 ns
// Notes: mode register fields, timing counts, register offsets
`ifndef ODT_CFG_SVH
`define ODT_CFG_SVH
`define MR1_DLL_DIS_BIT 0
`define MR1_RTT_B2 2
`define MR1_RTT_B6 6
`define MR1_RTT_B9 9
`define MR1_AL_LSB 3
`define MR1_TERMINATION_STROBE_BIT 11
`define MR2_CWL_LSB 3
`define MR2_WR_B9 9
`define MR2_WR_B10 10
`define MR0_CL_LSB 4
`define MR0_PD_FAST_BIT 12
`define CWL_BASE 5'h5
`define CL_BASE 5'h4
`define RELOCK_CK 4'ha
`define MIN_HIGH_SHORT 4'h4
`define MIN_HIGH_LONG 4'h6
`define BURST_CK_BL8 3'h4
`define BURST_CK_BC4 3'h2
`define READ_HOLD_CK 5'h8
`define REF_CLK_PS 40000
`define ASYNC_DLY_MIN_PS 2000
`define ASYNC_DLY_MAX_PS 8500
`define CK_HALF_CYC 2'h3
`define REG_CTRL 12'h000
`define REG_CMD 12'h004
`define REG_STATUS 12'h008
`endif

/* File: logic/odt_link_if.sv */
// Purpose: pins between memory controller and memory device
// Assumes: controller makes ck and changes all else at ck falling
// Notes: no two-way pins on this link
`timescale 1ns/1ps
`default_nettype none
interface odt_link_if;
  logic ck;
  logic cke;
  logic odt;
  logic reset_n;
  odt_pkg::op_t op;
  logic [15:0] arg;
  modport ctrl(output ck, output cke, output odt, output reset_n, output op, output arg);
  modport dram(input ck, input cke, input odt, input reset_n, input op, input arg);
endinterface
`default_nettype wire

/* File: logic/odt_pkg.sv */
// Purpose: shared types and the latency calculation
// Assumes: odt_cfg.svh field positions
// Notes: latency result never exceeds 20 cycles
`include "odt_cfg.svh"
package odt_pkg;
  typedef enum logic [3:0] {op_nop, op_mrs0, op_mrs1, op_mrs2, op_read, op_write_bl8,
    op_write_bc4, op_sr_enter, op_sr_exit, op_pd_enter, op_pd_exit} op_t;
  typedef enum logic [1:0] {ts_off, ts_nominal, ts_write} term_sel_t;
  typedef enum {dm_normal, dm_self_refresh, dm_pd_slow, dm_relock} dev_mode_t;

  function automatic logic [4:0] sync_latency(input logic [15:0] mr0, input logic [15:0] mr1,
      input logic [15:0] mr2);
    logic [4:0] cwl;
    logic [4:0] cl;
    logic [4:0] al;
    cwl = `CWL_BASE + {2'h0, mr2[`MR2_CWL_LSB +: 3]};
    cl = `CL_BASE + {2'h0, mr0[`MR0_CL_LSB +: 3]};
    unique case (mr1[`MR1_AL_LSB +: 2])
      2'h1: al = cl - 5'h1;
      2'h2: al = cl - 5'h2;
      default: al = 5'h0;
    endcase
    return cwl + al - 5'h2;
  endfunction
endpackage

/* File: logic/term_delay_line.sv */
// Purpose: ck-stepped shift line with a selectable tap
// Assumes: step is a one-cycle pulse per ck rising edge
// Notes: dout shows din from tap steps earlier
`timescale 1ns/1ps
`default_nettype none
module term_delay_line #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 24
) (
  input wire logic ref_clk,
  input wire logic clear,
  input wire logic step,
  input wire logic [WIDTH-1:0] din,
  input wire logic [4:0] tap,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage [DEPTH];

  if (DEPTH < 2 || DEPTH > 31) begin : bad_depth
    $error("term_delay_line depth out of range");
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_stage
    always_ff @(posedge ref_clk) begin
      if (clear) begin
        stage[i] <= '0;
      end else if (step) begin
        stage[i] <= (i == 0) ? din : stage[(i == 0) ? 0 : i - 1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      dout <= '0;
    end else if (step) begin
      dout <= (tap == 5'h0) ? din : stage[tap - 5'h1];
    end
  end
endmodule // term_delay_line
`default_nettype wire

/* File: tb/dram_on_die_termination_control_test.sv */
// Purpose: bench joining controller and device over the link
// Assumes: apb answers in the first access cycle; x8 device
// Notes: termination changes are checked in order through a queue
`timescale 1ns/1ps
`default_nettype none
module dram_on_die_termination_control_test;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} rd_note_t;
  typedef struct {odt_pkg::term_sel_t s; logic [3:0] v; logic [1:0] w; logic [12:0] p;
    logic a;} tn_t;
  logic am, wvf;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, async_mode, illegal_code;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [12:0] term_pins;
  odt_pkg::term_sel_t term_sel, last_sel;
  logic [3:0] nominal_divisor;
  logic [3:0] div_tab [8];
  logic [2:0] cl, cwl;
  logic [1:0] write_code, wc, al;
  int fail_count, num_checks, cycles;
  rd_note_t rd_q[$];
  tn_t tn_q[$];
  odt_link_if link();
  dram_odt_controller u_dram_odt_controller (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  dram_odt_device u_dram_odt_device (.ref_clk(ref_clk), .srst(srst), .link(link),
    .term_pins(term_pins), .term_sel(term_sel), .nominal_divisor(nominal_divisor),
    .write_code(write_code), .async_mode(async_mode), .illegal_code(illegal_code),
    .write_value_fault(wvf));
  odt_link_props u_odt_link_props (.ref_clk(ref_clk), .srst(srst), .ck(link.ck),
    .odt(link.odt), .op(link.op), .arg(link.arg), .term_sel(term_sel),
    .async_mode(async_mode), .illegal_code(illegal_code));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    rd_q.push_back('{d, m, e});
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctrl(input logic o);
    apb(1'b1, 12'h000, {29'h0, 2'h3, o}, 32'h0, 1'b0);
  endtask
  task automatic stat(input logic [31:0] d, input logic [31:0] m);
    apb(1'b0, 12'h008, d, m, 1'b0);
  endtask
  task automatic idle();
    q = 32'h1;
    while (q[0]) apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic cmd(input odt_pkg::op_t o, input logic [15:0] g);
    idle();
    apb(1'b1, 12'h004, {g, 12'h0, 4'(o)}, 32'h0, 1'b0);
  endtask
  task automatic mr1(input logic [2:0] c, input logic t, input logic dll);
    cmd(odt_pkg::op_mrs1, {4'h0, t, 1'b0, c[2], 2'h0, c[1], 1'b0, al, c[0], 1'b0, dll});
  endtask
  task automatic note(input odt_pkg::term_sel_t s, input logic [2:0] c, input logic t);
    tn_q.push_back('{s, div_tab[c], wc, (s == odt_pkg::ts_off) ? 13'h0 : {t, t, 11'h7ff}, am});
  endtask
  task automatic settle();
    while (tn_q.size() != 0) @(posedge ref_clk);
  endtask
  task automatic turn(input logic o, input logic [2:0] c, input logic t);
    note(o ? odt_pkg::ts_nominal : odt_pkg::ts_off, c, t);
    ctrl(o);
    settle();
  endtask
  task automatic chk_rd(input rd_note_t n);
    num_checks++;
    if (pslverr !== n.e || (prdata & n.m) !== (n.d & n.m)) begin
      fail_count++;
      $display("ERROR apb exp %h/%b seen %h/%b", n.d & n.m, n.e, prdata & n.m, pslverr);
    end
  endtask
  task automatic chk_term(input tn_t n);
    num_checks++;
    if (term_sel !== n.s || nominal_divisor !== n.v || write_code !== n.w ||
        term_pins !== n.p || async_mode !== n.a || wvf !== 1'b0) begin
      fail_count++;
      $display("ERROR term exp %0d/%h/%h/%h/%b/0 seen %0d/%h/%h/%h/%b/%b", n.s, n.v, n.w, n.p,
        n.a, term_sel, nominal_divisor, write_code, term_pins, async_mode, wvf);
    end
  endtask
  // result watcher and run limit
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) chk_rd(rd_q.pop_front());
    if (!srst && term_sel !== last_sel) begin
      if (tn_q.size() != 0) begin
        chk_term(tn_q.pop_front());
      end else begin
        fail_count++;
        $display("ERROR term exp none seen %0d", term_sel);
      end
    end
    last_sel = term_sel;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fail_count = 0;
    num_checks = 0;
    cycles = 0;
    wc = 2'h0;
    am = 1'b0;
    last_sel = odt_pkg::ts_off;
    div_tab = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hc, 4'h8, 4'h0, 4'h0};
    void'($urandom(32'h662b4754));
    cl = 3'($urandom_range(7, 0));
    cwl = 3'($urandom_range(7, 0));
    al = 2'($urandom_range(2, 0));
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    ctrl(1'b0);
    apb(1'b0, 12'h000, 32'h6, 32'h7, 1'b0);
    apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
    cmd(odt_pkg::op_mrs0, {9'h0, cl, 4'h0});
    cmd(odt_pkg::op_mrs2, {10'h0, cwl, 3'h0});
    for (int c = 1; c < 6; c++) begin
      mr1(3'(c), c == 5, 1'b0);
      turn(1'b1, 3'(c), c == 5);
      if (c == 4) begin
        cmd(odt_pkg::op_write_bl8, 16'h0);
        idle();
        stat(32'h4, 32'h4);
        apb(1'b1, 12'h008, 32'h4, 32'h0, 1'b0);
      end
      turn(1'b0, 3'(c), c == 5);
    end
    mr1(3'h6, 1'b0, 1'b0);
    idle();
    stat(32'h4, 32'h4);
    apb(1'b1, 12'h008, 32'h4, 32'h0, 1'b0);
    wc = 2'($urandom_range(3, 1));
    cmd(odt_pkg::op_mrs2, {5'h0, wc, 3'h0, cwl, 3'h0});
    mr1(3'h1, 1'b0, 1'b0);
    turn(1'b1, 3'h1, 1'b0);
    note(odt_pkg::ts_write, 3'h1, 1'b0);
    note(odt_pkg::ts_nominal, 3'h1, 1'b0);
    cmd(odt_pkg::op_write_bl8, 16'h0);
    settle();
    turn(1'b0, 3'h1, 1'b0);
    cmd(odt_pkg::op_sr_enter, 16'h0);
    ctrl(1'b1);
    idle();
    stat(32'h8, 32'ha);
    note(odt_pkg::ts_nominal, 3'h1, 1'b0);
    cmd(odt_pkg::op_sr_exit, 16'h0);
    settle();
    turn(1'b0, 3'h1, 1'b0);
    cmd(odt_pkg::op_read, 16'h0);
    idle();
    turn(1'b1, 3'h1, 1'b0);
    turn(1'b0, 3'h1, 1'b0);
    cmd(odt_pkg::op_pd_enter, 16'h0);
    idle();
    am = 1'b1;
    turn(1'b1, 3'h1, 1'b0);
    turn(1'b0, 3'h1, 1'b0);
    am = 1'b0;
    // flush the latency line before leaving power-down
    repeat (200) @(posedge ref_clk);
    cmd(odt_pkg::op_pd_exit, 16'h0);
    mr1(3'h1, 1'b0, 1'b1);
    idle();
    ctrl(1'b1);
    repeat (40) @(posedge ref_clk);
    stat(32'h0, 32'h2);
    ctrl(1'b0);
    complete_run();
  end
endmodule // dram_on_die_termination_control_test
`default_nettype wire

/* File: tb/odt_link_props.sv */
// Purpose: property checks on the link and the device's termination outputs
// Assumes: ck is 8 ref_clk cycles, one op per ck period
// Notes: latency rebuilt from the mode register ops seen on the link
`timescale 1ns/1ps
`default_nettype none
module odt_link_props (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ck,
  input wire logic odt,
  input wire odt_pkg::op_t op,
  input wire logic [15:0] arg,
  input wire odt_pkg::term_sel_t term_sel,
  input wire logic async_mode,
  input wire logic illegal_code
);
  logic [15:0] mr0, mr1, mr2;
  logic [8:0] hi_cnt, on_cnt, off_cnt, w8_cnt;
  logic in_sr, w8;
  int al, lat8;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  function automatic logic [8:0] inc(input logic [8:0] c);
    return (&c) ? c : c + 9'h1;
  endfunction
  assign al = (mr1[4:3] == 2'h1) ? 3 + int'(mr0[6:4]) :
              (mr1[4:3] == 2'h2) ? 2 + int'(mr0[6:4]) : 0;
  assign lat8 = 8 * (3 + int'(mr2[5:3]) + al);
  // mode register copies and self refresh state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mr0 <= 16'h0;
      mr1 <= 16'h0;
      mr2 <= 16'h0;
      in_sr <= 1'b0;
    end else begin
      if (op == odt_pkg::op_mrs0) mr0 <= arg;
      if (op == odt_pkg::op_mrs1) mr1 <= arg;
      if (op == odt_pkg::op_mrs2) mr2 <= arg;
      if (op == odt_pkg::op_sr_enter) in_sr <= 1'b1;
      else if (op == odt_pkg::op_sr_exit) in_sr <= 1'b0;
    end
  end
  // cycle counters since odt edges and long writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hi_cnt <= 9'h0;
      on_cnt <= 9'h0;
      off_cnt <= 9'h0;
      w8_cnt <= 9'h0;
      w8 <= 1'b0;
    end else begin
      hi_cnt <= odt ? inc(hi_cnt) : 9'h0;
      on_cnt <= $rose(odt) ? 9'h1 : inc(on_cnt);
      off_cnt <= $fell(odt) ? 9'h1 : inc(off_cnt);
      w8_cnt <= (op == odt_pkg::op_write_bl8) ? 9'h0 : inc(w8_cnt);
      if (op == odt_pkg::op_write_bl8 && odt) w8 <= 1'b1;
      else if (!odt) w8 <= 1'b0;
    end
  end
  sequence s_ck_rise;
    $rose(ck);
  endsequence
  sequence s_term_on;
    term_sel == odt_pkg::ts_nominal && $past(term_sel) == odt_pkg::ts_off && !async_mode;
  endsequence
  sequence s_term_off;
    term_sel == odt_pkg::ts_off && $past(term_sel) != odt_pkg::ts_off && !async_mode;
  endsequence
  property p_ck_period; s_ck_rise |-> ##8 $rose(ck); endproperty
  property p_odt_low_read; op == odt_pkg::op_read |-> !odt; endproperty
  property p_odt_low_sr; in_sr |-> !odt; endproperty
  property p_odt_low_dll; mr1[0] |-> !odt; endproperty
  property p_no_reserved; op == odt_pkg::op_mrs1 |-> !(arg[9] && arg[6]); endproperty
  property p_no_illegal; !illegal_code; endproperty
  property p_min_high; $fell(odt) |-> hi_cnt >= 9'h20; endproperty
  property p_bl8_high; $fell(odt) && w8 |-> w8_cnt >= 9'h28; endproperty
  property p_on_lat; s_term_on |-> on_cnt >= lat8 + 4 && on_cnt <= lat8 + 12; endproperty
  property p_off_lat; s_term_off |-> off_cnt >= lat8 + 4 && off_cnt <= lat8 + 12; endproperty
  a_ck_period: assert property (p_ck_period)
    else $error("ck period is not 8 cycles");
  a_odt_low_read: assert property (p_odt_low_read)
    else $error("odt high during read");
  a_odt_low_sr: assert property (p_odt_low_sr)
    else $error("odt high in self refresh");
  a_odt_low_dll: assert property (p_odt_low_dll)
    else $error("odt high with dll disabled");
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved nominal code sent");
  a_no_illegal: assert property (p_no_illegal)
    else $error("illegal code flagged");
  a_min_high: assert property (p_min_high)
    else $error("odt high shorter than 4 ck");
  a_bl8_high: assert property (p_bl8_high)
    else $error("odt high too short after long write");
  a_on_lat: assert property (p_on_lat)
    else $error("turn-on latency wrong");
  a_off_lat: assert property (p_off_lat)
    else $error("turn-off latency wrong");
endmodule // odt_link_props
`default_nettype wire
